// ### hdl/nwd_pkg.sv
// package: constants and carrier types for the network wake detector
package nwd_pkg;
	localparam int        NWD_FRAMES     = 4;
	localparam int        NWD_SYNC_LEN   = 6;
	localparam int        NWD_ADDR_REPS  = 16;
	localparam int        NWD_ADDR_BYTES = 6;
	localparam logic [7:0] NWD_SYNC_BYTE = 8'hFF;
	localparam logic [2:0] NWD_CAUSE_LINK    = 3'h1;
	localparam logic [2:0] NWD_CAUSE_FRAME   = 3'h2;
	localparam logic [2:0] NWD_CAUSE_PATTERN = 3'h4;

	typedef enum logic [1:0] {
		NWD_HUNT = 2'b00,
		NWD_SYNC = 2'b01,
		NWD_ADDR = 2'b10,
		NWD_DONE = 2'b11
	} nwd_mstate_type;

	// one received byte from the mac receive path
	typedef struct packed {
		logic       valid;
		logic       sof;
		logic       eof;
		logic       crc_ok;
		logic [7:0] data;
	} nwd_rx_type;

	// software controls
	typedef struct packed {
		logic                  link_wake_en;
		logic                  frame_wake_en;
		logic                  pattern_wake_en;
		logic [NWD_FRAMES-1:0] frame_valid;
		logic [47:0]           station_addr;
	} nwd_ctrl_type;
endpackage

// ### hdl/nwd_pattern_match.sv
// wake pattern matcher: sync stream followed by repeated station address
`timescale 1ns/100ps
module nwd_pattern_match (
	// clock and reset
	input  wire logic              clock_i,
	input  wire logic              reset_i,
	// receive byte stream, match enable and station address
	input  wire nwd_pkg::nwd_rx_type rx_i,
	input  wire logic              enable_i,
	input  wire logic [47:0]       station_addr_i,
	// result
	output logic                   found_o
);
	import nwd_pkg::*;

	typedef struct packed {
		nwd_mstate_type state;
		logic [2:0]     sync_cnt;
		logic [2:0]     byte_idx;
		logic [4:0]     rep_cnt;
		logic           found;
	} nwd_pm_type;

	nwd_pm_type cur;
	nwd_pm_type next_cur;
	logic [7:0] want;
	logic       is_ff;

	// address sent most significant byte first
	always_comb begin
		want = station_addr_i[8*(NWD_ADDR_BYTES-1-32'(cur.byte_idx)) +: 8];
		is_ff = rx_i.data == NWD_SYNC_BYTE;
	end

	always_comb begin
		next_cur = cur;
		next_cur.found = 1'b0;
		if (rx_i.valid && enable_i) begin
			case (cur.state)
			NWD_HUNT, NWD_SYNC: begin
				// a run of ff longer than six still counts as sync
				if (is_ff) begin
					if (cur.sync_cnt < 3'(NWD_SYNC_LEN))
						next_cur.sync_cnt = cur.sync_cnt + 3'h1;
					next_cur.state = NWD_SYNC;
				end else begin
					next_cur.sync_cnt = 3'h0;
					next_cur.state = NWD_HUNT;
				end
				if (cur.sync_cnt == 3'(NWD_SYNC_LEN) &&
				    rx_i.data == want) begin
					next_cur.state = NWD_ADDR;
					next_cur.byte_idx = 3'h1;
					next_cur.rep_cnt = 5'h0;
				end
			end
			NWD_ADDR: begin
				if (rx_i.data == want) begin
					if (cur.byte_idx == 3'(NWD_ADDR_BYTES-1)) begin
						next_cur.byte_idx = 3'h0;
						next_cur.rep_cnt = cur.rep_cnt + 5'h1;
						if (cur.rep_cnt == 5'(NWD_ADDR_REPS-1))
							next_cur.state = NWD_DONE;
					end else begin
						next_cur.byte_idx = cur.byte_idx + 3'h1;
					end
				end else begin
					next_cur.state = NWD_HUNT;
					next_cur.sync_cnt = is_ff ? 3'h1 : 3'h0;
					next_cur.byte_idx = 3'h0;
				end
			end
			NWD_DONE: begin
				next_cur.state = NWD_DONE;
			end
			default: begin
				next_cur.state = NWD_HUNT;
			end
			endcase
			// the match only stands once the frame check passed
			if (rx_i.eof) begin
				next_cur.found = (cur.state == NWD_DONE) && rx_i.crc_ok;
				next_cur.state = NWD_HUNT;
				next_cur.sync_cnt = 3'h0;
				next_cur.byte_idx = 3'h0;
				next_cur.rep_cnt = 5'h0;
			end
		end
		if (!enable_i || (rx_i.valid && rx_i.sof && !rx_i.eof &&
		    cur.state == NWD_DONE)) begin
			// a stale byte index would aim the next compare at the wrong byte
			next_cur.state = NWD_HUNT;
			next_cur.sync_cnt = 3'h0;
			next_cur.byte_idx = 3'h0;
			next_cur.rep_cnt = 5'h0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i)
			cur <= '{state: NWD_HUNT, default: '0};
		else
			cur <= next_cur;
	end

	assign found_o = cur.found;

	AST_PM_FOUND_NEEDS_CRC: assert property (@(posedge clock_i)
		disable iff (reset_i)
		found_o |-> $past(rx_i.eof) && $past(rx_i.crc_ok))
		else $error("pattern accepted without good crc");
	AST_PM_FOUND_FROM_DONE: assert property (@(posedge clock_i)
		disable iff (reset_i)
		found_o |-> $past(cur.state) == NWD_DONE)
		else $error("pattern accepted before sixteen copies");
	AST_PM_MISMATCH_RESETS: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(cur.state == NWD_ADDR && rx_i.valid && enable_i &&
		 rx_i.data != want) |=> cur.state != NWD_ADDR)
		else $error("address mismatch did not restart search");
endmodule

// ### hdl/nwd_wake_detect.sv
// network wake detector top: link, crc frame and pattern sources
`timescale 1ns/100ps
module nwd_wake_detect #(
	parameter int FRAMES = nwd_pkg::NWD_FRAMES
) (
	// clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   reset_i,
	// mac receive path
	input  wire nwd_pkg::nwd_rx_type    rx_i,
	input  wire logic [31:0]            rx_crc_i,
	// link state pin
	input  wire logic                   link_up_i,
	// software controls
	input  wire nwd_pkg::nwd_ctrl_type  ctrl_i,
	input  wire logic [FRAMES*32-1:0]   frame_crc_i,
	input  wire logic                   cause_clear_i,
	// system wake output and status
	output logic                        wake_o,
	output logic [2:0]                  cause_o
);
	import nwd_pkg::*;

	typedef struct packed {
		logic       link_s1;
		logic       link_s2;
		logic       link_prev;
		logic [2:0] settle;
		logic [2:0] cause;
		logic       wake;
	} nwd_top_type;

	nwd_top_type      cur;
	nwd_top_type      next_cur;
	logic [FRAMES-1:0] crc_hit;
	logic             pat_found;
	logic [2:0]       event_vec;

	nwd_pattern_match u_match (
		.clock_i        (clock_i),
		.reset_i        (reset_i),
		.rx_i           (rx_i),
		.enable_i       (ctrl_i.pattern_wake_en),
		.station_addr_i (ctrl_i.station_addr),
		.found_o        (pat_found)
	);

	// each programmed frame compares its crc independently
	for (genvar g = 0; g < FRAMES; g++) begin : g_crc
		assign crc_hit[g] = ctrl_i.frame_valid[g] &&
			rx_crc_i == frame_crc_i[32*g +: 32];
	end

	always_comb begin
		next_cur = cur;
		next_cur.link_s1 = link_up_i;
		next_cur.link_s2 = cur.link_s1;
		next_cur.link_prev = cur.link_s2;
		// sync stages and edge register start at zero, so a pin that is
		// already up at reset would look like a change until all three
		// hold a real pin level
		next_cur.settle = {cur.settle[1:0], 1'b1};
		event_vec = 3'h0;
		if (cur.settle[2] && ctrl_i.link_wake_en &&
		    cur.link_s2 != cur.link_prev)
			event_vec = event_vec | NWD_CAUSE_LINK;
		if (ctrl_i.frame_wake_en && rx_i.valid && rx_i.eof &&
		    rx_i.crc_ok && |crc_hit)
			event_vec = event_vec | NWD_CAUSE_FRAME;
		if (pat_found)
			event_vec = event_vec | NWD_CAUSE_PATTERN;
		// a new event wins over a clear in the same cycle
		if (cause_clear_i)
			next_cur.cause = 3'h0;
		next_cur.cause = next_cur.cause | event_vec;
		next_cur.wake = |next_cur.cause;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign wake_o = cur.wake;
	assign cause_o = cur.cause;

	sequence s_pattern_seen;
		pat_found;
	endsequence
	sequence s_wake_raised;
		wake_o && cause_o[2];
	endsequence

	AST_PATTERN_WAKES: assert property (@(posedge clock_i)
		disable iff (reset_i) s_pattern_seen |=> s_wake_raised)
		else $error("pattern match did not raise wake");
	AST_SET_WINS_CLEAR: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(cause_clear_i && event_vec != 3'h0) |=> cause_o != 3'h0)
		else $error("event lost under clear");
	AST_WAKE_TRACKS_CAUSE: assert property (@(posedge clock_i)
		disable iff (reset_i) wake_o == (cause_o != 3'h0))
		else $error("wake output disagrees with cause");
	AST_FRAME_CAUSE: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(rx_i.valid && rx_i.eof && rx_i.crc_ok && ctrl_i.frame_wake_en
		 && |crc_hit) |=> cause_o[1])
		else $error("crc frame match not recorded");
	AST_CAUSE_STICKY: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(cause_o[0] && !cause_clear_i) |=> cause_o[0])
		else $error("link cause dropped without clear");

	sequence s_link_pin_moved;
		$changed(link_up_i);
	endsequence

	sequence s_link_armed;
		ctrl_i.link_wake_en && cur.settle[2];
	endsequence

	sequence s_frame_end_good;
		rx_i.valid && rx_i.eof && rx_i.crc_ok;
	endsequence

	sequence s_frame_slot_hit;
		ctrl_i.frame_wake_en && |crc_hit;
	endsequence

	// the pin change needs two sync edges before it can be seen
	AST_LINK_CHANGE_WAKES: assert property (@(posedge clock_i)
		disable iff (reset_i)
		s_link_pin_moved ##2 s_link_armed |=> cause_o[0] && wake_o)
		else $error("link change did not raise wake");

	AST_LINK_MASKED: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(!ctrl_i.link_wake_en && !cause_o[0]) |=> !cause_o[0])
		else $error("link cause set while link wake off");

	AST_LINK_SETTLING: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(!cur.settle[2] && !cause_o[0]) |=> !cause_o[0])
		else $error("link cause set before sync settled");

	AST_LINK_NEEDS_MOVE: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(!cause_o[0] && cur.link_s2 == cur.link_prev) |=> !cause_o[0])
		else $error("link cause set with steady link");

	AST_FRAME_WAKES: assert property (@(posedge clock_i)
		disable iff (reset_i)
		s_frame_end_good ##0 s_frame_slot_hit |=> wake_o)
		else $error("crc frame match did not raise wake");

	AST_FRAME_NEEDS_EN: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(!ctrl_i.frame_wake_en && !cause_o[1]) |=> !cause_o[1])
		else $error("frame cause set while frame wake off");

	AST_FRAME_NEEDS_GOOD_END: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(!cause_o[1] && !(rx_i.valid && rx_i.eof && rx_i.crc_ok))
		|=> !cause_o[1])
		else $error("frame cause set without good frame end");

	AST_FRAME_NEEDS_SLOT: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(!cause_o[1] && ctrl_i.frame_valid == '0) |=> !cause_o[1])
		else $error("frame cause set with no slot in use");

	AST_PATTERN_NEEDS_MATCH: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(!pat_found && !cause_o[2]) |=> !cause_o[2])
		else $error("pattern cause set without a match");

	AST_PATTERN_NEEDS_EN: assert property (@(posedge clock_i)
		disable iff (reset_i)
		pat_found |-> $past(ctrl_i.pattern_wake_en))
		else $error("pattern match while pattern wake off");

	AST_FRAME_STICKY: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(cause_o[1] && !cause_clear_i) |=> cause_o[1])
		else $error("frame cause dropped without clear");

	AST_PATTERN_STICKY: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(cause_o[2] && !cause_clear_i) |=> cause_o[2])
		else $error("pattern cause dropped without clear");

	AST_CLEAR_EMPTIES: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(cause_clear_i && event_vec == 3'h0) |=> cause_o == 3'h0)
		else $error("clear left a cause standing");

	AST_CLEAR_KEEPS_EVENT: assert property (@(posedge clock_i)
		disable iff (reset_i)
		cause_clear_i |=> cause_o == $past(event_vec))
		else $error("clear did not leave just the new events");

	AST_CAUSE_HAS_SOURCE: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(cause_o != 3'h0 && $past(cause_o) == 3'h0)
		|-> $past(event_vec) != 3'h0)
		else $error("cause appeared with no event");

	AST_WAKE_HOLDS: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(wake_o && !cause_clear_i) |=> wake_o)
		else $error("wake dropped without clear");

	AST_NO_SPONTANEOUS_WAKE: assert property (@(posedge clock_i)
		disable iff (reset_i)
		(!wake_o && event_vec == 3'h0) |=> !wake_o)
		else $error("wake raised with no event");

	// reset must leave both outputs idle on the next edge
	AST_RESET_QUIET: assert property (@(posedge clock_i)
		reset_i |=> !wake_o && cause_o == 3'h0)
		else $error("outputs not idle after reset");
endmodule

// ### test/nwd_rx_model.sv
// mac receive path model: plays frames byte by byte into the detector
`timescale 1ns/100ps
module nwd_rx_model (
	// clock
	input  wire logic           clock_i,
	// receive stream toward the detector
	output nwd_pkg::nwd_rx_type rx_o,
	output logic [31:0]         crc_o
);
	import nwd_pkg::*;
	initial begin
		rx_o  = '0;
		crc_o = '0;
	end
	// slow mode drops valid now and then; idle data flips so a stale
	// byte can never pass for a fresh one
	task automatic send(input logic [7:0] f[$], input logic good,
		input logic [31:0] crc, input logic slow);
		for (int i = 0; i < f.size(); i++) begin
			if (slow && i % 3 == 1) begin
				rx_o.valid = 1'b0;
				rx_o.data  = ~rx_o.data;
				@(posedge clock_i);
				#1;
			end
			rx_o.valid  = 1'b1;
			rx_o.sof    = (i == 0);
			rx_o.eof    = (i == f.size() - 1);
			rx_o.crc_ok = rx_o.eof && good;
			rx_o.data   = f[i];
			crc_o       = rx_o.eof ? crc : ~crc;
			@(posedge clock_i);
			#1;
		end
		rx_o  = '{1'b0, 1'b0, 1'b0, 1'b0, ~rx_o.data};
		crc_o = ~crc_o;
	endtask
endmodule

// ### test/nwd_wake_detect_bench.sv
// self-checking bench for the network wake detector
`timescale 1ns/100ps
module nwd_wake_detect_bench;
	import nwd_pkg::*;
	logic         clock_i = 0;
	logic         reset_i = 1;
	nwd_rx_type   rx;
	logic [31:0]  crc;
	logic         link = 0;
	nwd_ctrl_type ctrl = '0;
	logic [127:0] fcrc = '0;
	logic         clr = 0;
	logic         wake;
	logic [2:0]   cause;
	logic [7:0]   f[$];
	logic [3:0]   q[$];
	int           seed = 82411;
	int           n_mismatch = 0;
	int           total_checks = 0;
	int           cyc = 0;
	event         probe;
	always #2.5 clock_i = ~clock_i;
	nwd_rx_model i_model (.clock_i(clock_i), .rx_o(rx), .crc_o(crc));
	nwd_wake_detect #(.FRAMES(4)) i_dut (.clock_i(clock_i),
		.reset_i(reset_i), .rx_i(rx), .rx_crc_i(crc), .link_up_i(link),
		.ctrl_i(ctrl), .frame_crc_i(fcrc), .cause_clear_i(clr),
		.wake_o(wake), .cause_o(cause));
	task automatic check(input string nm, input logic [3:0] s, e);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask
	task automatic complete_run;
		if (n_mismatch == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(probe) check("wake_cause", {wake, cause}, q.pop_front());
	always @(posedge clock_i) if (++cyc == 20000) begin
		n_mismatch++;
		complete_run;
	end
	// clear is held two edges so either clear latency reads back zero
	task automatic note(input logic [2:0] c);
		repeat (2) @(posedge clock_i);
		#1;
		q.push_back({|c, c});
		->probe;
		clr = 1;
		repeat (2) @(posedge clock_i);
		#1;
		clr = 0;
		q.push_back(4'h0);
		->probe;
	endtask
	task automatic run(input int pre, sy, reps, input logic gap, bc, ok,
		sl, input logic [31:0] fc, input logic [2:0] c);
		f.delete();
		for (int i = 0; i < 6; i++)
			f.push_back(bc ? 8'hFF : ctrl.station_addr[47-8*i -: 8]);
		repeat (pre) f.push_back(8'($random(seed)) & 8'h7F);
		repeat (sy) f.push_back(NWD_SYNC_BYTE);
		for (int r = 0; r < reps; r++) begin
			if (gap && r == 8) f.push_back(8'h00);
			for (int b = 0; b < 6; b++)
				f.push_back(ctrl.station_addr[47-8*b -: 8]);
		end
		repeat (3) f.push_back(8'h5A);
		i_model.send(f, ok, fc, sl);
		note(c);
	endtask
	initial begin
		// top bits cleared so no address byte can pose as a sync byte
		ctrl.station_addr = 48'({$random(seed), $random(seed)})
			& 48'h7F7F7F7F7F7F;
		for (int g = 0; g < 4; g++)
			fcrc[32*g +: 32] = $random(seed) | 32'h80000000;
		repeat (5) @(posedge clock_i);
		#1;
		q.push_back(4'h0);
		->probe;
		reset_i = 0;
		ctrl.link_wake_en = 1;
		ctrl.frame_wake_en = 1;
		ctrl.pattern_wake_en = 1;
		ctrl.frame_valid = 4'hF;
		repeat (4) @(posedge clock_i);
		#1;
		run(3, 6, 16, 0, 1, 1, 0, 0, 3'h4);
		run(0, 7, 16, 0, 0, 1, 1, 0, 3'h4);
		run(2, 5, 16, 0, 1, 1, 0, 0, 3'h0);
		run(2, 6, 15, 0, 1, 1, 0, 0, 3'h0);
		run(2, 6, 16, 1, 1, 1, 1, 0, 3'h0);
		run(2, 6, 16, 0, 0, 0, 0, 0, 3'h0);
		ctrl.pattern_wake_en = 0;
		run(2, 6, 16, 0, 1, 1, 0, 0, 3'h0);
		for (int g = 0; g < 4; g++) begin
			run(8, 0, 0, 0, 0, 1, 1, fcrc[32*g +: 32], 3'h2);
			ctrl.frame_valid[g] = 0;
			run(8, 0, 0, 0, 0, 1, 0, fcrc[32*g +: 32], 3'h0);
		end
		link = 1;
		repeat (2) @(posedge clock_i);
		#1;
		// clear lands in the very cycle of the link event: set must win
		clr = 1;
		@(posedge clock_i);
		#1;
		clr = 0;
		repeat (3) @(posedge clock_i);
		#1;
		note(3'h1);
		ctrl.link_wake_en = 0;
		link = 0;
		repeat (6) @(posedge clock_i);
		#1;
		note(3'h0);
		// link already up when reset lets go: no change to report
		link = 1;
		ctrl.link_wake_en = 1;
		reset_i = 1;
		repeat (2) @(posedge clock_i);
		#1;
		reset_i = 0;
		repeat (6) @(posedge clock_i);
		#1;
		note(3'h0);
		complete_run;
	end
endmodule
